// ### hdl/rip_prio.v
module rip_prio (
    input  wire [5:0] req_i,
    output reg  [2:0] idx_o,
    output reg        any_o
);
    integer k;

    // Lowest index is highest rank
    always @* begin
        idx_o = 3'h0;
        any_o = 1'b0;
        for (k = 5; k >= 0; k = k - 1) begin
            if (req_i[k]) begin
                idx_o = k[2:0];
                any_o = 1'b1;
            end
        end
    end
endmodule

// ### hdl/rip_sync2.v
module rip_sync2 (
    input  wire MCLK_I,
    input  wire RESET_N_I,
    input  wire CE_I,
    input  wire d_i,
    output reg  q_o
);
    reg meta;

    // Idles high so a pin reads released out of reset
    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            meta <= 1'b1;
            q_o  <= 1'b1;
        end else if (CE_I) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ### hdl/rip_top.v
// Behaviour
// - Reset overrides all, leaves maskables disabled
// - Five external pins; four enable and mask gated
// - NMI beats maskables; blocked by NMI or reset
// - Peripheral requests gated by mask; enable gates lines two-six only
// - Vectored instruction uses operand, sets global disable
// - NMI instruction vectors 24h, sets global disable
// - Trap vectors 22h, leaves global disable alone
// - Reset from five merged causes
// - Watchdog overflow or bad key/control write resets
// - Watchdog runs from power-on
// - Clearing keep bit or setting force bit resets
// - Illegal frame access resets
// - Reset pin driven low eight cycles minimum
// - Stay reset while either pin low
// - Reset clears control state, not RAM
// - Power-on reset also clears multiplier control
// - Cause flags recorded, never cleared by reset
// - Nine ranked lines, highest acknowledged first
// - Ranks: reset, reserved, NMI, lines one-six
// - Global disable set at reset and non-trap acks
// - Maskable ack needs mask bit and disable clear
`include "rip_regs.vh"
module rip_top (
    input  wire       MCLK_I,
    input  wire       RESET_N_I,
    input  wire       CE_I,
    input  wire       SYS_RESET_PIN_N_I,
    input  wire       POWER_ON_RESET_PIN_N_I,
    input  wire       NMI_PIN_N_I,
    input  wire       EXT_IRQ_ONE_I,
    input  wire       EXT_IRQ_TWO_I,
    input  wire       EXT_IRQ_THREE_I,
    input  wire       DRIVE_PROTECT_IRQ_I,
    input  wire [2:0] EXT_EN_I,
    input  wire       DRIVE_PROTECT_EN_I,
    input  wire [5:0] PERIPH_REQ_I,
    input  wire [5:0] PERIPH_EN_I,
    input  wire [5:0] LINE_MASK_REG_I,
    input  wire       GDIS_SET_I,
    input  wire       GDIS_CLR_I,
    input  wire       VECTORED_SOFT_IRQ_INSTR_I,
    input  wire [5:0] VECTORED_OPERAND_I,
    input  wire       SOFT_NMI_INSTR_I,
    input  wire       TRAP_INSTR_I,
    input  wire       NMI_DONE_I,
    input  wire       ACK_READY_I,
    input  wire       SYSTEM_CONTROL_REG_WR_I,
    input  wire [15:0] SYSTEM_CONTROL_REG_WDATA_I,
    input  wire       WD_KEY_WR_I,
    input  wire [7:0] WD_KEY_I,
    input  wire       WD_CTRL_WR_I,
    input  wire [2:0] WD_CHK_I,
    input  wire       WD_TICK_I,
    input  wire       ILLEGAL_ACCESS_I,
    input  wire       PLL_CTRL_WR_I,
    input  wire [15:0] PLL_CTRL_WDATA_I,
    output reg        SYS_RESET_PIN_N_O,
    output reg        SYS_RESET_PIN_OE_O,
    output reg        CORE_RESET_O,
    output reg        GLOBAL_IRQ_DISABLE_O,
    output reg        ACK_O,
    output reg  [5:0] ACK_VECTOR_O,
    output reg  [3:0] ACK_RANK_O,
    output reg  [15:0] SYSTEM_STATUS_REG_O,
    output reg  [15:0] SYSTEM_CONTROL_REG_O,
    output reg  [15:0] PLL_CTRL_O,
    output reg        NMI_ACTIVE_O
);

    // =================================================================
    // Pin synchronisers
    wire rs_pin_n;
    wire por_pin_n;
    wire nmi_pin_n;

    rip_sync2 u_sync_rs (
        .MCLK_I    (MCLK_I),
        .RESET_N_I (RESET_N_I),
        .CE_I      (CE_I),
        .d_i       (SYS_RESET_PIN_N_I),
        .q_o       (rs_pin_n)
    );

    rip_sync2 u_sync_por (
        .MCLK_I    (MCLK_I),
        .RESET_N_I (RESET_N_I),
        .CE_I      (CE_I),
        .d_i       (POWER_ON_RESET_PIN_N_I),
        .q_o       (por_pin_n)
    );

    rip_sync2 u_sync_nmi (
        .MCLK_I    (MCLK_I),
        .RESET_N_I (RESET_N_I),
        .CE_I      (CE_I),
        .d_i       (NMI_PIN_N_I),
        .q_o       (nmi_pin_n)
    );

    // Level pins from outside also need two stages
    reg [3:0] ext_meta;
    reg [3:0] ext_sync;

    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            ext_meta <= 4'h0;
            ext_sync <= 4'h0;
        end else if (CE_I) begin
            ext_meta <= {DRIVE_PROTECT_IRQ_I, EXT_IRQ_THREE_I,
                         EXT_IRQ_TWO_I, EXT_IRQ_ONE_I};
            ext_sync <= ext_meta;
        end
    end

    // =================================================================
    // Watchdog
    reg [7:0] wd_count;
    reg       wd_fire;
    wire      wd_bad_key;
    wire      wd_bad_ctrl;

    assign wd_bad_key  = WD_KEY_WR_I && (WD_KEY_I != `RIP_WD_KEY_OK) &&
                         (WD_KEY_I != `RIP_WD_KEY_OK2);
    assign wd_bad_ctrl = WD_CTRL_WR_I && (WD_CHK_I != `RIP_WD_CHK);

    // Counter restarts on reset so it runs with no setup
    always @(posedge MCLK_I) begin
        if (!RESET_N_I || (CE_I && CORE_RESET_O)) begin
            wd_count <= 8'h00;
            wd_fire  <= 1'b0;
        end else if (CE_I) begin
            wd_fire <= 1'b0;
            if (WD_KEY_WR_I && (WD_KEY_I == `RIP_WD_KEY_OK2)) begin
                wd_count <= 8'h00;
            end else if (WD_TICK_I) begin
                wd_count <= wd_count + 8'h01;
            end
            if ((WD_TICK_I && wd_count == `RIP_WD_TOP) ||
                wd_bad_key || wd_bad_ctrl) begin
                wd_fire <= 1'b1;
            end
        end
    end

    // =================================================================
    // Software reset and illegal access
    wire sw_fire;
    assign sw_fire = SYSTEM_CONTROL_REG_WR_I && !CORE_RESET_O &&
                     (!SYSTEM_CONTROL_REG_WDATA_I[`RIP_SYSTEM_CONTROL_REG_KEEP] ||
                      SYSTEM_CONTROL_REG_WDATA_I[`RIP_SYSTEM_CONTROL_REG_FORCE]);

    reg sw_hit;
    reg ill_hit;
    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            sw_hit  <= 1'b0;
            ill_hit <= 1'b0;
        end else if (CE_I) begin
            sw_hit  <= sw_fire;
            ill_hit <= ILLEGAL_ACCESS_I && !CORE_RESET_O;
        end
    end

    // =================================================================
    // Reset merge and pin pulse
    localparam [3:0] PULSE_LEN = `RIP_PULSE_CYC;
    reg  [3:0] pulse_cnt;
    reg        rs_armed;
    wire       int_cause;
    wire       ext_hold;
    wire       por_low;

    assign por_low   = !por_pin_n;
    // Own drive reads back on the pin, so a pin fall only counts
    // once the pin was seen released while we were not driving it
    assign int_cause = wd_fire || sw_hit || ill_hit ||
                       (rs_armed && !rs_pin_n);
    assign ext_hold  = por_low || (!rs_pin_n && pulse_cnt == 4'h0);

    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            pulse_cnt          <= PULSE_LEN;
            rs_armed           <= 1'b0;
            SYS_RESET_PIN_N_O  <= 1'b0;
            SYS_RESET_PIN_OE_O <= 1'b1;
            CORE_RESET_O       <= 1'b1;
        end else if (CE_I) begin
            if (int_cause || por_low) begin
                pulse_cnt <= PULSE_LEN;
            end else if (pulse_cnt != 4'h0) begin
                pulse_cnt <= pulse_cnt - 4'h1;
            end
            SYS_RESET_PIN_N_O  <= 1'b0;
            rs_armed           <= rs_pin_n && !SYS_RESET_PIN_OE_O;
            SYS_RESET_PIN_OE_O <= int_cause || por_low ||
                                  (pulse_cnt > 4'h1);
            CORE_RESET_O <= int_cause || ext_hold ||
                            (pulse_cnt != 4'h0);
        end
    end

    // =================================================================
    // Cause flags, never cleared by reset
    reg por_seen;

    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            SYSTEM_STATUS_REG_O <= 16'h0000;
            por_seen            <= 1'b0;
        end else if (CE_I) begin
            por_seen <= por_low;
            if (por_low) begin
                SYSTEM_STATUS_REG_O[`RIP_SYSTEM_STATUS_REG_POR] <= 1'b1;
            end
            if (ill_hit) begin
                SYSTEM_STATUS_REG_O[`RIP_SYSTEM_STATUS_REG_ILL] <= 1'b1;
            end
            if (sw_hit) begin
                SYSTEM_STATUS_REG_O[`RIP_SYSTEM_STATUS_REG_SW] <= 1'b1;
            end
            if (wd_fire) begin
                SYSTEM_STATUS_REG_O[`RIP_SYSTEM_STATUS_REG_WD] <= 1'b1;
            end
        end
    end

    // =================================================================
    // System control and multiplier control
    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            SYSTEM_CONTROL_REG_O <= `RIP_SYSTEM_CONTROL_REG_RESET;
            PLL_CTRL_O           <= 16'h0000;
        end else if (CE_I) begin
            if (CORE_RESET_O) begin
                SYSTEM_CONTROL_REG_O <= `RIP_SYSTEM_CONTROL_REG_RESET;
            end else if (SYSTEM_CONTROL_REG_WR_I && !sw_fire) begin
                SYSTEM_CONTROL_REG_O <= SYSTEM_CONTROL_REG_WDATA_I;
            end
            if (por_seen) begin
                PLL_CTRL_O <= 16'h0000;
            end else if (PLL_CTRL_WR_I && !CORE_RESET_O) begin
                PLL_CTRL_O <= PLL_CTRL_WDATA_I;
            end
        end
    end

    // =================================================================
    // Interrupt arbitration
    wire [5:0] line_req;
    wire [5:0] line_ok;
    wire [2:0] win_idx;
    wire       win_any;
    reg        nmi_prev;
    wire       nmi_edge;

    // Line one carries the external requests; line five carries drive protect
    assign line_req[0] = PERIPH_REQ_I[0] || (ext_sync[0] && EXT_EN_I[0]) ||
                         (ext_sync[1] && EXT_EN_I[1]) ||
                         (ext_sync[2] && EXT_EN_I[2]);
    assign line_req[1] = PERIPH_REQ_I[1] && PERIPH_EN_I[1];
    assign line_req[2] = PERIPH_REQ_I[2] && PERIPH_EN_I[2];
    assign line_req[3] = PERIPH_REQ_I[3] && PERIPH_EN_I[3];
    assign line_req[4] = (PERIPH_REQ_I[4] && PERIPH_EN_I[4]) ||
                         (ext_sync[3] && DRIVE_PROTECT_EN_I);
    assign line_req[5] = PERIPH_REQ_I[5] && PERIPH_EN_I[5];
    assign line_ok = (GLOBAL_IRQ_DISABLE_O) ? 6'h00 :
                     (line_req & LINE_MASK_REG_I);
    assign nmi_edge = nmi_prev && !nmi_pin_n;

    rip_prio u_prio (
        .req_i (line_ok),
        .idx_o (win_idx),
        .any_o (win_any)
    );

    reg nmi_pend;
    always @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            nmi_prev             <= 1'b1;
            nmi_pend             <= 1'b0;
            NMI_ACTIVE_O         <= 1'b0;
            GLOBAL_IRQ_DISABLE_O <= 1'b1;
            ACK_O                <= 1'b0;
            ACK_VECTOR_O         <= `RIP_VEC_RESET;
            ACK_RANK_O           <= 4'h1;
        end else if (CE_I) begin
            nmi_prev <= nmi_pin_n;
            ACK_O    <= 1'b0;
            if (CORE_RESET_O) begin
                nmi_pend             <= 1'b0;
                NMI_ACTIVE_O         <= 1'b0;
                GLOBAL_IRQ_DISABLE_O <= 1'b1;
                ACK_VECTOR_O         <= `RIP_VEC_RESET;
                ACK_RANK_O           <= 4'h1;
            end else begin
                if (nmi_edge) begin
                    nmi_pend <= 1'b1;
                end
                if (NMI_DONE_I) begin
                    NMI_ACTIVE_O <= 1'b0;
                end
                if (GDIS_SET_I) begin
                    GLOBAL_IRQ_DISABLE_O <= 1'b1;
                end else if (GDIS_CLR_I) begin
                    GLOBAL_IRQ_DISABLE_O <= 1'b0;
                end
                if (!ACK_READY_I) begin
                    // Core busy: requests wait pending
                end else if ((nmi_pend || SOFT_NMI_INSTR_I) &&
                             !NMI_ACTIVE_O) begin
                    nmi_pend             <= nmi_edge;
                    NMI_ACTIVE_O         <= 1'b1;
                    ACK_O                <= 1'b1;
                    ACK_VECTOR_O         <= `RIP_VEC_NMI;
                    ACK_RANK_O           <= 4'h3;
                    GLOBAL_IRQ_DISABLE_O <= 1'b1;
                end else if (win_any) begin
                    ACK_O        <= 1'b1;
                    ACK_VECTOR_O <= `RIP_VEC_INT1 +
                                    {win_idx, 1'b0};
                    ACK_RANK_O   <= {1'b0, win_idx} + 4'h4;
                    GLOBAL_IRQ_DISABLE_O <= 1'b1;
                end else if (VECTORED_SOFT_IRQ_INSTR_I) begin
                    ACK_O                <= 1'b1;
                    ACK_VECTOR_O         <= VECTORED_OPERAND_I;
                    ACK_RANK_O           <= 4'h0;
                    GLOBAL_IRQ_DISABLE_O <= 1'b1;
                end else if (TRAP_INSTR_I) begin
                    ACK_O        <= 1'b1;
                    ACK_VECTOR_O <= `RIP_VEC_TRAP;
                    ACK_RANK_O   <= 4'h0;
                end
            end
        end
    end
endmodule

// ### inc/rip_regs.vh
`ifndef RIP_REGS_VH
`define RIP_REGS_VH
// =====================================================================
// Vectors
`define RIP_VEC_RESET      6'h00
`define RIP_VEC_TRAP       6'h22
`define RIP_VEC_NMI        6'h24
`define RIP_VEC_INT1       6'h02
`define RIP_VEC_STEP       6'h02
// =====================================================================
// Control and status bit positions
`define RIP_SYSTEM_CONTROL_REG_KEEP     14
`define RIP_SYSTEM_CONTROL_REG_FORCE    15
`define RIP_SYSTEM_CONTROL_REG_RESET    16'h4000
`define RIP_SYSTEM_STATUS_REG_POR      15
`define RIP_SYSTEM_STATUS_REG_ILL      12
`define RIP_SYSTEM_STATUS_REG_SW       10
`define RIP_SYSTEM_STATUS_REG_WD       9
`define RIP_ST0_GDIS       9
// =====================================================================
// Timing
`define RIP_PULSE_MIN_NS   160
`define RIP_CLK_NS         20
`define RIP_PULSE_CYC      4'h8
`define RIP_WD_KEY_OK      8'h55
`define RIP_WD_KEY_OK2     8'haa
`define RIP_WD_CHK         3'h5
`define RIP_WD_TOP         8'hff
`endif

// ### tb/rip_asserts.sv
module rip_asserts (
    input wire        MCLK_I,
    input wire        RESET_N_I,
    input wire        POWER_ON_RESET_PIN_N_I,
    input wire        SYSTEM_CONTROL_REG_WR_I,
    input wire [15:0] SYSTEM_CONTROL_REG_WDATA_I,
    input wire        ILLEGAL_ACCESS_I,
    input wire        GDIS_SET_I,
    input wire        GDIS_CLR_I,
    input wire        SYS_RESET_PIN_OE_O,
    input wire        CORE_RESET_O,
    input wire        GLOBAL_IRQ_DISABLE_O,
    input wire        ACK_O,
    input wire [5:0]  ACK_VECTOR_O,
    input wire [3:0]  ACK_RANK_O,
    input wire [15:0] SYSTEM_STATUS_REG_O,
    input wire [15:0] PLL_CTRL_O,
    input wire        NMI_ACTIVE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);
    // ==========
    // Reset causes
    sequence sw_req;
        SYSTEM_CONTROL_REG_WR_I && !CORE_RESET_O
            && (SYSTEM_CONTROL_REG_WDATA_I[15] || !SYSTEM_CONTROL_REG_WDATA_I[14]);
    endsequence
    sequence ill_req;
        ILLEGAL_ACCESS_I && !CORE_RESET_O;
    endsequence
    chk_pin_pulse_len: assert property (
        $rose(SYS_RESET_PIN_OE_O) |-> SYS_RESET_PIN_OE_O[*8])
        else $error("reset pin pulse too short");
    chk_sw_reset_flag: assert property (
        sw_req |-> ##2 SYS_RESET_PIN_OE_O && SYSTEM_STATUS_REG_O[10])
        else $error("software reset not taken");
    chk_ill_reset_flag: assert property (
        ill_req |-> ##2 SYS_RESET_PIN_OE_O && SYSTEM_STATUS_REG_O[12])
        else $error("illegal access reset not taken");
    chk_flags_sticky: assert property (
        ($past(SYSTEM_STATUS_REG_O) & ~SYSTEM_STATUS_REG_O
            & 16'h9600) == 16'h0000)
        else $error("cause flag cleared");
    chk_por_holds: assert property (
        (!POWER_ON_RESET_PIN_N_I)[*5]
            |-> CORE_RESET_O && PLL_CTRL_O == 16'h0000)
        else $error("power-on pin low without full reset");
    // ==========
    // Acknowledge
    chk_reset_masks: assert property (
        CORE_RESET_O && $past(CORE_RESET_O)
            |-> GLOBAL_IRQ_DISABLE_O && !ACK_O)
        else $error("acknowledge or enable during reset");
    chk_trap_keeps: assert property (
        ACK_O && ACK_VECTOR_O == 6'h22 && ACK_RANK_O == 4'h0
            && !$past(GDIS_SET_I) && !$past(GDIS_CLR_I)
            |-> $stable(GLOBAL_IRQ_DISABLE_O))
        else $error("trap changed global disable");
    chk_nmi_rank: assert property (
        ACK_O && ACK_RANK_O == 4'h3 |-> ACK_VECTOR_O == 6'h24
            && GLOBAL_IRQ_DISABLE_O && !$past(NMI_ACTIVE_O))
        else $error("bad nonmaskable acknowledge");
    chk_line_rank: assert property (
        ACK_O && ACK_RANK_O >= 4'h4 |-> ACK_RANK_O <= 4'h9
            && ACK_VECTOR_O == {1'b0, ACK_RANK_O - 4'h3, 1'b0}
            && !$past(GLOBAL_IRQ_DISABLE_O) && GLOBAL_IRQ_DISABLE_O)
        else $error("bad maskable acknowledge");
endmodule

bind rip_top rip_asserts chk_u (.*);

// ### tb/rip_ext_reset.sv
module rip_ext_reset (
    input  wire drive_oe_i,
    input  wire por_req_i,
    input  wire pin_req_i,
    output wire por_n_o,
    output wire pin_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pulled-up shared pin: low while either party pulls it
    assign pin_n_o = !(drive_oe_i || pin_req_i);
    // Power-on requests are held by the bench for several cycles
    assign por_n_o = !por_req_i;
endmodule

// ### tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, por_req, pin_req, nmi_n, x2, dp, dp_en;
    logic        gset, gclr, vsi, snmi, trap, ndone, sc_wr, k_wr;
    logic        c_wr, tick, ill, p_wr;
    logic [2:0]  x_en, chk;
    logic [5:0]  preq, pen, mask, vop;
    logic [7:0]  key;
    logic [15:0] sc_d, p_d;
    wire         por_n, pin_n, oe, core, gdis, ack, nact, pin_d;
    wire  [5:0]  avec;
    wire  [3:0]  arank;
    wire  [15:0] ssr, scr, pll;
    int          errors, n_compared, i, k;

    rip_ext_reset ext_u (.drive_oe_i(oe), .por_req_i(por_req),
        .pin_req_i(pin_req), .por_n_o(por_n), .pin_n_o(pin_n));
    rip_top dut_u (
        .MCLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1),
        .SYS_RESET_PIN_N_I(pin_n), .POWER_ON_RESET_PIN_N_I(por_n),
        .NMI_PIN_N_I(nmi_n), .EXT_IRQ_ONE_I(1'b0), .EXT_IRQ_TWO_I(x2),
        .EXT_IRQ_THREE_I(1'b0), .DRIVE_PROTECT_IRQ_I(dp),
        .EXT_EN_I(x_en), .DRIVE_PROTECT_EN_I(dp_en),
        .PERIPH_REQ_I(preq), .PERIPH_EN_I(pen), .LINE_MASK_REG_I(mask),
        .GDIS_SET_I(gset), .GDIS_CLR_I(gclr),
        .VECTORED_SOFT_IRQ_INSTR_I(vsi), .VECTORED_OPERAND_I(vop),
        .SOFT_NMI_INSTR_I(snmi), .TRAP_INSTR_I(trap),
        .NMI_DONE_I(ndone), .ACK_READY_I(1'b1),
        .SYSTEM_CONTROL_REG_WR_I(sc_wr), .SYSTEM_CONTROL_REG_WDATA_I(sc_d),
        .WD_KEY_WR_I(k_wr), .WD_KEY_I(key), .WD_CTRL_WR_I(c_wr),
        .WD_CHK_I(chk), .WD_TICK_I(tick), .ILLEGAL_ACCESS_I(ill),
        .PLL_CTRL_WR_I(p_wr), .PLL_CTRL_WDATA_I(p_d),
        .SYS_RESET_PIN_N_O(pin_d), .SYS_RESET_PIN_OE_O(oe),
        .CORE_RESET_O(core), .GLOBAL_IRQ_DISABLE_O(gdis), .ACK_O(ack),
        .ACK_VECTOR_O(avec), .ACK_RANK_O(arank),
        .SYSTEM_STATUS_REG_O(ssr), .SYSTEM_CONTROL_REG_O(scr),
        .PLL_CTRL_O(pll), .NMI_ACTIVE_O(nact));

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // ==========
    // Tasks
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        errors++;
        $display("[FAIL] %0t wait ran out", $time);
        summarize();
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk);
        s = 0;
    endtask
    task automatic rst_seen(input int b);
        int n;
        n = 0;
        for (i = 0; i < 20 && oe !== 1'b1; i++) @(negedge clk);
        while (oe === 1'b1 && n < 60) begin
            n++;
            @(negedge clk);
        end
        cmp(n >= 8, 1);
        for (i = 0; i < 40 && core !== 1'b0; i++) @(negedge clk);
        if (core !== 1'b0) timeout();
        cmp(ssr[b], 1);
    endtask
    task automatic wait_ack(input logic [5:0] v, input logic [3:0] r,
                            input logic g);
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge clk);
        if (ack !== 1'b1) timeout();
        cmp(avec, v);
        cmp(arank, r);
        cmp(gdis, g);
        @(negedge clk);
    endtask
    task automatic quiet;
        repeat (6) begin
            @(negedge clk);
            cmp(ack, 0);
        end
    endtask
    // ==========
    // Sequence
    initial begin
        {rst_n, pin_req, x2, dp, dp_en, gset, gclr, vsi, snmi} = 0;
        {trap, ndone, sc_wr, k_wr, c_wr, tick, ill, p_wr} = 0;
        {x_en, preq, vop, p_d, errors, n_compared} = 0;
        {por_req, nmi_n, pen, mask} = {2'b11, 6'h3f, 6'h3f};
        sc_d = 16'h4000;
        key = 8'h55;
        chk = 3'h5;
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (6) @(negedge clk);
        por_req = 0;
        rst_seen(15);
        cmp(pll, 16'h0000);
        cmp(gdis, 1);
        cmp(pin_d, 0);
        cmp(scr, 16'h4000);
        p_d = 16'h1234;
        pulse(p_wr);
        for (k = 0; k < 2; k++) begin
            sc_d = k ? 16'h0000 : 16'hc000;
            pulse(sc_wr);
            rst_seen(10);
            cmp(scr, 16'h4000);
        end
        cmp(pll, 16'h1234);
        pulse(ill);
        rst_seen(12);
        key = 8'h12;
        pulse(k_wr);
        rst_seen(9);
        chk = 3'h2;
        pulse(c_wr);
        rst_seen(9);
        for (k = 0; k < 300 && oe !== 1'b1; k++) begin
            pulse(tick);
            @(negedge clk);
        end
        cmp(k inside {[254:257]}, 1);
        rst_seen(9);
        cmp(ssr & 16'h9600, 16'h9600);
        pin_req = 1;
        repeat (20) @(negedge clk);
        cmp(core, 1);
        pin_req = 0;
        repeat (6) @(negedge clk);
        cmp(core, 0);
        pulse(pin_req);
        rst_seen(15);
        pulse(trap);
        wait_ack(6'h22, 0, 1);
        pulse(gclr);
        pulse(trap);
        wait_ack(6'h22, 0, 0);
        pulse(gset);
        cmp(gdis, 1);
        pulse(gclr);
        {mask, preq} = {6'h3b, 6'h04};
        quiet();
        {mask, pen} = {6'h3f, 6'h3b};
        quiet();
        pen = 6'h3f;
        wait_ack(6'h06, 6, 1);
        preq = 6'h12;
        pulse(gclr);
        wait_ack(6'h04, 5, 1);
        preq = 6'h10;
        pulse(gclr);
        wait_ack(6'h0a, 8, 1);
        preq = 0;
        nmi_n = 0;
        wait_ack(6'h24, 3, 1);
        nmi_n = 1;
        repeat (3) @(negedge clk);
        nmi_n = 0;
        quiet();
        cmp(nact, 1);
        {preq, gclr, ndone} = {6'h01, 2'b11};
        @(negedge clk);
        {gclr, ndone} = 0;
        wait_ack(6'h24, 3, 1);
        pulse(ndone);
        pulse(gclr);
        wait_ack(6'h02, 4, 1);
        {preq, nmi_n, x_en, x2, dp} = {6'h00, 1'b1, 3'h5, 2'b11};
        pulse(gclr);
        quiet();
        x_en = 3'h7;
        wait_ack(6'h02, 4, 1);
        x2 = 0;
        dp_en = 1;
        repeat (2) @(negedge clk);
        pulse(gclr);
        wait_ack(6'h0a, 8, 1);
        dp = 0;
        vop = 6'h10;
        repeat (2) @(negedge clk);
        pulse(gclr);
        pulse(vsi);
        wait_ack(6'h10, 0, 1);
        pulse(gclr);
        pulse(snmi);
        wait_ack(6'h24, 3, 1);
        por_req = 1;
        repeat (6) @(negedge clk);
        cmp(pll, 16'h0000);
        por_req = 0;
        rst_seen(15);
        summarize();
    end
endmodule
